// >>> rtl/gdsb_pkg.sv
// package: constants and types for the gate driver status bank
//
// Function
// - bit 15 high until link fault seen
// - bit 14 ORs all faults, mirrors pin
// - bit 13 ORs warnings except thermal warning
// - bit 12 ORs drain-source overcurrent flags
// - bit 11 ORs gate-source fault flags
// - bit 10 ORs sense overcurrent on phases
// - bit 9 ORs supply overvoltage flags
// - bit 8 ORs supply undervoltage flags
// - bit 1 reports thermal warning
// - bit 0 mirrors driver enable control
// - word 1h bits 10-8 sense A,B,C
// - word 1h bits 5-0 drain per MOSFET
// - word 2h bits 5-0 gate per MOSFET
// - word 3h supply pairs and bootstrap pairs
// - read-only; reset summary 8000h, others zero
// - first response bit carries summary fault
// - thermal warning latched until clear command
// - frame is 8 command bits, 16 data
package gdsb_pkg;

  localparam int WORD_W     = 16;
  localparam int CMD_W      = 8;
  localparam int FRAME_BITS = 24;
  localparam int NUM_WORDS  = 6;
  localparam int CNT_W      = 6;

  localparam int IDX_SUMMARY = 0;
  localparam int IDX_OVERCUR = 1;
  localparam int IDX_GATE    = 2;
  localparam int IDX_RAIL    = 3;
  localparam int IDX_MISC_A  = 4;
  localparam int IDX_MISC_B  = 5;

  localparam logic [15:0] RST_SUMMARY = 16'h8000;
  localparam logic [15:0] RST_DETAIL  = 16'h0000;

  localparam int SUM_LINK_OK = 15;
  localparam int SUM_FAULT   = 14;
  localparam int SUM_WARN    = 13;
  localparam int SUM_DRAIN   = 12;
  localparam int SUM_GATE    = 11;
  localparam int SUM_SENSE   = 10;
  localparam int SUM_HIGH    = 9;
  localparam int SUM_LOW     = 8;
  localparam int SUM_THERM   = 1;
  localparam int SUM_DRV     = 0;

  localparam int OC_SENSE_LSB = 8;
  localparam int OC_DRAIN_LSB = 0;
  localparam int GATE_LSB     = 0;
  localparam int RAIL_LSB     = 8;
  localparam int BOOT_LSB     = 0;

  // over flags sit on odd bits, under flags on even bits
  localparam logic [15:0] HIGH_MASK = 16'hAA2A;
  localparam logic [15:0] LOW_MASK  = 16'h5515;

  typedef logic [NUM_WORDS-1:0][WORD_W-1:0] gdsb_bank_t;

  typedef struct packed {
    logic [2:0]  sense_oc;     // [2]=A .. [0]=C
    logic [5:0]  drain_oc;     // [5]=A high .. [0]=C low
    logic [5:0]  gate_flt;     // [5]=A high .. [0]=C low
    logic [7:0]  rail_ovuv;    // main, drain, pump, gate: ov,uv
    logic [5:0]  boot_ovuv;    // A, B, C: ov,uv
    logic        thermal_warn;
    logic        other_warn;
    logic [15:0] misc_a;
    logic [15:0] misc_b;
  } gdsb_mon_t;

endpackage

// >>> rtl/gdsb_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module gdsb_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = reset_n ? d : RST;
    q_next    = reset_n ? meta_reg : RST;
  end

  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q_reg    <= q_next;
  end

  assign q = q_reg;

endmodule // gdsb_sync
`default_nettype wire

// >>> rtl/gdsb_link.sv
// serial link slave on the link clock: command capture and read-out
`timescale 1ns/10ps
`default_nettype none
module gdsb_link (
  input  wire logic                       sclk,
  input  wire logic                       reset_n,
  input  wire logic                       cs_n,
  input  wire logic                       sdi,
  input  wire gdsb_pkg::gdsb_bank_t       bank,
  output logic                            sdo,
  output logic                            sdo_oe_n,
  output logic                            frame_tog,
  output logic [gdsb_pkg::CNT_W-1:0]      bit_cnt
);

  localparam logic [gdsb_pkg::CNT_W-1:0] CNT_MAX = '1;
  localparam logic [gdsb_pkg::CNT_W-1:0] CNT_CMD =
    gdsb_pkg::CNT_W'(gdsb_pkg::CMD_W);
  localparam logic [gdsb_pkg::CNT_W-1:0] CNT_END =
    gdsb_pkg::CNT_W'(gdsb_pkg::FRAME_BITS);
  localparam logic [gdsb_pkg::CNT_W-1:0] CNT_ONE =
    {{(gdsb_pkg::CNT_W-1){1'b0}}, 1'b1};

  logic                          in_frame_reg;
  logic [gdsb_pkg::CNT_W-1:0]    cnt_reg;
  logic [gdsb_pkg::CNT_W-1:0]    cnt_next;
  logic                          tog_reg;
  logic                          tog_next;
  logic [gdsb_pkg::CMD_W-1:0]    rx_reg;
  logic [gdsb_pkg::CMD_W-1:0]    rx_next;
  logic                          sdo_reg;
  logic                          sdo_next;
  logic                          oe_n_reg;
  logic [6:0]                    addr;
  logic [gdsb_pkg::WORD_W-1:0]   word;
  logic [3:0]                    sel;

  // ------------------------------------------------------------
  // falling edge: capture
  // ------------------------------------------------------------
  always_comb begin
    tog_next = tog_reg;
    cnt_next = cnt_reg;
    rx_next  = rx_reg;
    if (!in_frame_reg) begin
      // first edge of a frame; toggle tells the core edges occurred
      tog_next = ~tog_reg;
      cnt_next = CNT_ONE;
      rx_next  = {{(gdsb_pkg::CMD_W-1){1'b0}}, sdi};
    end else begin
      if (cnt_reg != CNT_MAX) begin
        cnt_next = cnt_reg + 1'b1;
      end
      if (cnt_reg < CNT_CMD) begin
        rx_next = {rx_reg[gdsb_pkg::CMD_W-2:0], sdi};
      end
    end
  end

  // in-frame flag cleared by the select itself, no edge needed
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // count and toggle survive the frame so the core can judge it
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      tog_reg <= 1'b0;
      rx_reg  <= '0;
    end else begin
      cnt_reg <= cnt_next;
      tog_reg <= tog_next;
      rx_reg  <= rx_next;
    end
  end

  // ------------------------------------------------------------
  // rising edge: read-out
  // ------------------------------------------------------------
  always_comb begin
    addr = rx_reg[gdsb_pkg::CMD_W-1:1];
    word = '0;
    // unlisted addresses read zero; the write bit is ignored
    if (addr < 7'(gdsb_pkg::NUM_WORDS)) begin
      word = bank[addr[2:0]];
    end
    sel      = 4'(gdsb_pkg::FRAME_BITS - 1 - int'(cnt_reg));
    sdo_next = 1'b0;
    if (!in_frame_reg) begin
      sdo_next = bank[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_FAULT];
    end else if (cnt_reg < CNT_CMD) begin
      sdo_next = rx_reg[0];
    end else if (cnt_reg < CNT_END) begin
      sdo_next = word[sel];
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      sdo_reg  <= sdo_next;
      oe_n_reg <= 1'b0;
    end
  end

  assign sdo       = sdo_reg;
  assign sdo_oe_n  = oe_n_reg;
  assign frame_tog = tog_reg;
  assign bit_cnt   = cnt_reg;

endmodule // gdsb_link
`default_nettype wire

// >>> rtl/gdsb_status_bank.sv
// top: status bank, link health, snapshot handed to the serial link
`timescale 1ns/10ps
`default_nettype none
module gdsb_status_bank (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                sdi,
  input  wire gdsb_pkg::gdsb_mon_t mon,
  input  wire logic                driver_enable_ctrl,
  input  wire logic                clear_latched_faults,
  output logic                     sdo,
  output logic                     sdo_oe_n,
  output logic                     fault_pin_n
);

  localparam int MON_W = $bits(gdsb_pkg::gdsb_mon_t);
  localparam logic [gdsb_pkg::CNT_W-1:0] CNT_END =
    gdsb_pkg::CNT_W'(gdsb_pkg::FRAME_BITS);

  // ------------------------------------------------------------
  // crossings
  // ------------------------------------------------------------
  gdsb_pkg::gdsb_mon_t          mon_s;
  logic [1:0]                   ln_s;
  logic                         cs_s;
  logic                         tog_s;
  logic                         frame_tog;
  logic [gdsb_pkg::CNT_W-1:0]   bit_cnt;
  gdsb_pkg::gdsb_bank_t         snap_reg;

  gdsb_sync #(
    .W   (MON_W),
    .RST ('0)
  ) u_mon_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (mon),
    .q       (mon_s)
  );

  // select idles high; toggle flips once per frame with clocks
  gdsb_sync #(
    .W   (2),
    .RST (2'h2)
  ) u_link_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({cs_n, frame_tog}),
    .q       (ln_s)
  );

  assign cs_s  = ln_s[1];
  assign tog_s = ln_s[0];

  gdsb_link u_link (
    .sclk      (sclk),
    .reset_n   (reset_n),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .bank      (snap_reg),
    .sdo       (sdo),
    .sdo_oe_n  (sdo_oe_n),
    .frame_tog (frame_tog),
    .bit_cnt   (bit_cnt)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  gdsb_pkg::gdsb_bank_t bank_reg;
  gdsb_pkg::gdsb_bank_t bank_next;
  gdsb_pkg::gdsb_bank_t snap_next;
  logic                 otw_reg;
  logic                 otw_next;
  logic                 link_err_reg;
  logic                 link_err_next;
  logic                 cs_prev_reg;
  logic                 cs_prev_next;
  logic                 tog_seen_reg;
  logic                 tog_seen_next;
  logic                 fault_pin_n_reg;
  logic                 fault_pin_n_next;
  logic                 frame_end;
  logic                 bad_frame;
  logic                 fault_any;
  logic [15:0]          rail_w;

  always_comb begin
    frame_end = cs_s & ~cs_prev_reg;
    // bit count is frozen once select is high, so it is safe to read
    bad_frame = frame_end && (tog_s != tog_seen_reg) &&
                (bit_cnt != CNT_END);
    tog_seen_next = frame_end ? tog_s : tog_seen_reg;
    cs_prev_next  = cs_s;

    // set wins over clear for both latched flags
    link_err_next = link_err_reg;
    otw_next      = otw_reg;
    if (clear_latched_faults) begin
      link_err_next = 1'b0;
      otw_next      = 1'b0;
    end
    if (bad_frame) begin
      link_err_next = 1'b1;
    end
    if (mon_s.thermal_warn) begin
      otw_next = 1'b1;
    end

    rail_w = '0;
    rail_w[gdsb_pkg::RAIL_LSB +: 8] = mon_s.rail_ovuv;
    rail_w[gdsb_pkg::BOOT_LSB +: 6] = mon_s.boot_ovuv;

    fault_any = (|mon_s.drain_oc) | (|mon_s.gate_flt) |
                (|mon_s.sense_oc) | (|rail_w) | link_err_reg |
                (|mon_s.misc_a) | (|mon_s.misc_b);

    bank_next = '0; // reserved bits stay zero
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_LINK_OK] =
      ~link_err_reg;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_FAULT] =
      fault_any;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_WARN] =
      mon_s.other_warn;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_DRAIN] =
      |mon_s.drain_oc;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_GATE] =
      |mon_s.gate_flt;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_SENSE] =
      |mon_s.sense_oc;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_HIGH] =
      |(rail_w & gdsb_pkg::HIGH_MASK);
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_LOW] =
      |(rail_w & gdsb_pkg::LOW_MASK);
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_THERM] =
      otw_reg;
    bank_next[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_DRV] =
      driver_enable_ctrl;
    bank_next[gdsb_pkg::IDX_OVERCUR][gdsb_pkg::OC_SENSE_LSB +: 3] =
      mon_s.sense_oc;
    bank_next[gdsb_pkg::IDX_OVERCUR][gdsb_pkg::OC_DRAIN_LSB +: 6] =
      mon_s.drain_oc;
    bank_next[gdsb_pkg::IDX_GATE][gdsb_pkg::GATE_LSB +: 6] =
      mon_s.gate_flt;
    bank_next[gdsb_pkg::IDX_RAIL]   = rail_w;
    bank_next[gdsb_pkg::IDX_MISC_A] = mon_s.misc_a;
    bank_next[gdsb_pkg::IDX_MISC_B] = mon_s.misc_b;

    fault_pin_n_next = ~fault_any;

    // the link reads the snapshot; it holds still while a frame runs
    snap_next = cs_s ? bank_reg : snap_reg;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bank_reg        <= '0;
      bank_reg[gdsb_pkg::IDX_SUMMARY] <= gdsb_pkg::RST_SUMMARY;
      snap_reg        <= '0;
      snap_reg[gdsb_pkg::IDX_SUMMARY] <= gdsb_pkg::RST_SUMMARY;
      otw_reg         <= 1'b0;
      link_err_reg    <= 1'b0;
      cs_prev_reg     <= 1'b1;
      tog_seen_reg    <= 1'b0;
      fault_pin_n_reg <= 1'b1;
    end else begin
      bank_reg        <= bank_next;
      snap_reg        <= snap_next;
      otw_reg         <= otw_next;
      link_err_reg    <= link_err_next;
      cs_prev_reg     <= cs_prev_next;
      tog_seen_reg    <= tog_seen_next;
      fault_pin_n_reg <= fault_pin_n_next;
    end
  end

  assign fault_pin_n = fault_pin_n_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reset_words: assert property (
    $rose(reset_n) |->
      bank_reg[gdsb_pkg::IDX_SUMMARY] == gdsb_pkg::RST_SUMMARY &&
      bank_reg[gdsb_pkg::IDX_RAIL] == gdsb_pkg::RST_DETAIL)
    else $error("status words not at reset value");

  a_link_drop: assert property (
    bad_frame ##1 !clear_latched_faults |->
      ##1 !bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_LINK_OK])
    else $error("link ok bit not cleared after bad frame");

  a_fault_pin_mirror: assert property (
    fault_pin_n_reg == !bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_FAULT])
    else $error("fault pin and summary fault bit differ");

  a_fault_from_drain: assert property (
    |bank_reg[gdsb_pkg::IDX_OVERCUR] |-> !fault_pin_n_reg)
    else $error("overcurrent flagged but fault pin high");

  a_warn_no_thermal: assert property (
    mon_s.thermal_warn && !mon_s.other_warn |=>
      !bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_WARN])
    else $error("thermal warning leaked into warning summary");

  a_drain_summary: assert property (
    bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_DRAIN] ==
      |bank_reg[gdsb_pkg::IDX_OVERCUR][5:0])
    else $error("drain summary disagrees with detail");

  a_gate_summary: assert property (
    bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_GATE] ==
      |bank_reg[gdsb_pkg::IDX_GATE][5:0] &&
      bank_reg[gdsb_pkg::IDX_GATE][15:6] == 10'h000)
    else $error("gate summary or reserved bits wrong");

  a_sense_summary: assert property (
    bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_SENSE] ==
      |bank_reg[gdsb_pkg::IDX_OVERCUR][10:8] &&
      bank_reg[gdsb_pkg::IDX_OVERCUR][15:11] == 5'h00)
    else $error("sense summary or reserved bits wrong");

  a_rail_summary: assert property (
    bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_HIGH] ==
      |(bank_reg[gdsb_pkg::IDX_RAIL] & gdsb_pkg::HIGH_MASK) &&
    bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_LOW] ==
      |(bank_reg[gdsb_pkg::IDX_RAIL] & gdsb_pkg::LOW_MASK))
    else $error("supply summaries disagree with rail word");

  a_thermal_set: assert property (
    mon_s.thermal_warn |-> ##2
      bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_THERM])
    else $error("thermal warning not reported");

  a_thermal_hold: assert property (
    otw_reg && !clear_latched_faults |=> otw_reg)
    else $error("thermal warning dropped without clear");

  a_drv_mirror: assert property (
    ##1 bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_DRV] ==
      $past(driver_enable_ctrl))
    else $error("driver enable mirror lags or wrong");

  a_reserved_zero: assert property (
    bank_reg[gdsb_pkg::IDX_SUMMARY][7:2] == 6'h00 &&
    bank_reg[gdsb_pkg::IDX_RAIL][7:6] == 2'h0)
    else $error("reserved status bits not zero");

  a_snap_frozen: assert property (
    !cs_s && !$past(cs_s) |-> snap_reg == $past(snap_reg))
    else $error("snapshot changed during a frame");

  a_sense_detail: assert property (
    ##1 bank_reg[gdsb_pkg::IDX_OVERCUR][gdsb_pkg::OC_SENSE_LSB +: 3] ==
      $past(mon_s.sense_oc))
    else $error("sense detail bits not per phase");

  a_drain_detail: assert property (
    ##1 bank_reg[gdsb_pkg::IDX_OVERCUR][gdsb_pkg::OC_DRAIN_LSB +: 6] ==
      $past(mon_s.drain_oc))
    else $error("drain detail bits out of order");

  a_gate_detail: assert property (
    ##1 bank_reg[gdsb_pkg::IDX_GATE][gdsb_pkg::GATE_LSB +: 6] ==
      $past(mon_s.gate_flt))
    else $error("gate detail bits out of order");

  a_rail_detail: assert property (
    ##1 bank_reg[gdsb_pkg::IDX_RAIL] ==
      {$past(mon_s.rail_ovuv), 2'h0, $past(mon_s.boot_ovuv)})
    else $error("supply rail word layout wrong");

  a_warn_summary: assert property (
    ##1 bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_WARN] ==
      $past(mon_s.other_warn))
    else $error("warning summary does not follow warnings");

  a_link_err_set: assert property (
    bad_frame |=> link_err_reg)
    else $error("bad frame did not latch link fault");

  a_link_clear: assert property (
    clear_latched_faults && !bad_frame |=> !link_err_reg)
    else $error("link fault not cleared by clear command");

  a_therm_clear: assert property (
    clear_latched_faults && !mon_s.thermal_warn |=> !otw_reg)
    else $error("thermal warning not cleared by clear command");

  a_link_fault_pin: assert property (
    !bank_reg[gdsb_pkg::IDX_SUMMARY][gdsb_pkg::SUM_LINK_OK] |->
      !fault_pin_n_reg)
    else $error("link fault did not pull fault pin low");

  a_fault_from_rail: assert property (
    (|bank_reg[gdsb_pkg::IDX_GATE]) || (|bank_reg[gdsb_pkg::IDX_RAIL]) |->
      !fault_pin_n_reg)
    else $error("gate or supply fault but fault pin high");

endmodule // gdsb_status_bank
`default_nettype wire

// >>> verif/gdsb_spi_master.sv
// serial link master model standing in for the external controller
`timescale 1ns/10ps
`default_nettype none
module gdsb_spi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi  = 1'h0;
  end

  // ----------------------------------------
  // one frame of n clocks
  // ----------------------------------------
  // n other than 0 or 24 is a framing error on purpose
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx, output logic oe_ok);
    rx    = '0;
    oe_ok = 1'h1;
    #7;
    cs_n = 1'h0; // sclk low at both select edges
    #110;
    for (int k = 0; k < n; k++) begin
      sclk = 1'h1;
      sdi  = (k < 24) ? tx[23-k] : ~sdi; // command then data, msb first
      #6;
      rx    = {rx[22:0], sdo};
      oe_ok = oe_ok & ~sdo_oe_n;
      sclk  = 1'h0;
      #6;
    end
    cs_n = 1'h1;
    // released line must not keep its last level
    sdi  = ~sdi;
    #410;
  endtask
endmodule // gdsb_spi_master
`default_nettype wire

// >>> verif/gdsb_status_bank_tb.sv
// self-checking bench for the gate driver status bank
`timescale 1ns/10ps
`default_nettype none
module gdsb_status_bank_tb;
  logic                clk;
  logic                reset_n;
  logic                sclk;
  logic                cs_n;
  logic                sdi;
  logic                sdo;
  logic                sdo_oe_n;
  logic                fault_pin_n;
  logic                driver_enable_ctrl;
  logic                clear_latched_faults;
  gdsb_pkg::gdsb_mon_t mon;
  logic                link_ok;
  logic                therm;
  int                  errors;
  int                  compares;

  gdsb_status_bank dut (
    .clk                  (clk),
    .reset_n              (reset_n),
    .sclk                 (sclk),
    .cs_n                 (cs_n),
    .sdi                  (sdi),
    .mon                  (mon),
    .driver_enable_ctrl   (driver_enable_ctrl),
    .clear_latched_faults (clear_latched_faults),
    .sdo                  (sdo),
    .sdo_oe_n             (sdo_oe_n),
    .fault_pin_n          (fault_pin_n)
  );

  gdsb_spi_master master (
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo      (sdo),
    .sdo_oe_n (sdo_oe_n)
  );

  initial clk = 1'h0;
  always #12.5 clk = ~clk;

  // ----------------------------------------
  // compares and expectations
  // ----------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_w(input int idx);
    logic [15:0] rail;
    logic        flt;
    rail = {mon.rail_ovuv, 2'h0, mon.boot_ovuv};
    flt  = |{mon.drain_oc, mon.gate_flt, mon.sense_oc, rail,
             mon.misc_a, mon.misc_b, ~link_ok};
    case (idx)
      0: return {link_ok, flt, mon.other_warn, |mon.drain_oc,
                 |mon.gate_flt, |mon.sense_oc,
                 |(rail & gdsb_pkg::HIGH_MASK), |(rail & gdsb_pkg::LOW_MASK),
                 6'h00, therm, driver_enable_ctrl};
      1: return {5'h00, mon.sense_oc, 2'h0, mon.drain_oc};
      2: return {10'h000, mon.gate_flt};
      3: return rail;
      4: return mon.misc_a;
      5: return mon.misc_b;
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------
  // link access
  // ----------------------------------------
  task automatic rd(input logic [6:0] a, input logic rw, input int n,
                    output logic [23:0] rx);
    logic ok;
    master.xfer({a, rw, 16'hFFFF}, n, rx, ok);
    if (n > 0) cmp1(ok, 1'h1, "sdo enable in frame");
    cmp1(sdo_oe_n, 1'h1, "sdo enable idle");
  endtask

  task automatic chk_all();
    logic [23:0] rx;
    logic [15:0] sum;
    sum = exp_w(0);
    cmp1(fault_pin_n, ~sum[gdsb_pkg::SUM_FAULT], "fault pin");
    for (int a = 0; a < 7; a++) begin
      rd(a[6:0], 1'h1, 24, rx);
      cmp1(rx[23], sum[gdsb_pkg::SUM_FAULT], "first response bit");
      cmp16({9'h000, rx[22:16]}, {9'h000, a[6:0]}, "address echo");
      cmp16(rx[15:0], exp_w(a), "status word");
    end
  endtask

  task automatic settle();
    repeat (5) @(negedge clk);
  endtask

  task automatic clr();
    @(negedge clk);
    clear_latched_faults = 1'h1;
    @(negedge clk);
    clear_latched_faults = 1'h0;
    therm   = 1'h0;
    link_ok = 1'h1;
    settle();
  endtask

  task automatic results();
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [23:0] rx;
    int          n;
    errors   = 0;
    compares = 0;
    reset_n  = 1'h0;
    mon      = '0;
    driver_enable_ctrl   = 1'h0;
    clear_latched_faults = 1'h0;
    link_ok  = 1'h1;
    therm    = 1'h0;
    repeat (16) @(negedge clk);
    reset_n = 1'h1;
    settle();
    chk_all();
    // walking one over every monitor input, then its removal
    for (int i = 0; i < $bits(mon); i++) begin
      @(negedge clk);
      mon    = '0;
      mon[i] = 1'h1;
      driver_enable_ctrl = i[0];
      if (mon.thermal_warn) therm = 1'h1;
      settle();
      chk_all();
      mon = '0;
      settle();
      chk_all();
      clr();
    end
    // framing errors and an empty frame
    for (int j = 0; j < 4; j++) begin
      n = (j == 0) ? 0 : (j == 1) ? 1 : (j == 2) ? 23 : 25;
      rd(7'h00, 1'h1, n, rx);
      link_ok = (n == 0);
      settle();
      chk_all();
      clr();
    end
    // write attempt to a listed address returns data and changes nothing
    @(negedge clk);
    mon.drain_oc = 6'h21;
    settle();
    rd(7'h01, 1'h0, 24, rx);
    cmp16(rx[15:0], exp_w(1), "write returns data");
    chk_all();
    results();
  end

  initial begin
    // tests need under a millisecond; this limit is 2 ms, 80k clocks
    #2000000;
    errors++;
    results();
  end
endmodule // gdsb_status_bank_tb
`default_nettype wire
